// File: hw/bssx_exec.sv
// execution logic for skip-if-bit-clear and subtract-accumulator-from-file
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps

module bssx_exec
   import bssx_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input  wire logic                       i_clk_sys,
   input  wire logic                       i_rst,
   // instruction issue from the decoder
   input  wire logic                       i_issue,
   input  wire logic [bssx_pkg::OPCODE_W-1:0] i_opcode,
   input  wire logic [bssx_pkg::DATA_W-1:0] i_file_register_operand,
   input  wire logic [bssx_pkg::DATA_W-1:0] i_w,
   input  wire logic                       i_carry,
   output logic                            o_ready,
   output logic [bssx_pkg::FR_ADDR_W-1:0]  o_fr_addr,
   // write-back to file and status flags
   output logic                            o_fr_we,
   output logic [bssx_pkg::FR_ADDR_W-1:0]  o_fr_waddr,
   output logic [bssx_pkg::DATA_W-1:0]     o_fr_wdata,
   output logic                            o_flags_we,
   output logic                            o_carry,
   output logic                            o_nibble_borrow_flag,
   output logic                            o_zero,
   output logic                            o_skip,
   // apb slave
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [ADDR_W-1:0]          paddr,
   input  wire logic [31:0]                pwdata,
   output logic                            pready,
   output logic                            pslverr,
   output logic [31:0]                     prdata
);
   import bssx_pkg::*;

   // ==========================================================
   // helpers
   function automatic logic [DATA_W:0] sub_borrow(
      input logic [DATA_W-1:0] a,
      input logic [DATA_W-1:0] b,
      input logic              bin
   );
      sub_borrow = {1'b0, a} - {1'b0, b} - {{DATA_W{1'b0}}, bin};
   endfunction : sub_borrow

   function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
      reg_hit = (a == ADDR_W'(EXT_FUSE_CFG_OFS))
             || (a == ADDR_W'(EXEC_STATUS_OFS));
   endfunction : reg_hit

   // read mux for the setup-phase latch; unmapped offsets read zero
   function automatic logic [31:0] read_word(
      input logic [ADDR_W-1:0] a,
      input logic              fuse,
      input logic [DATA_W-1:0] res,
      input logic              c,
      input logic              dc,
      input logic              z,
      input logic              skp
   );
      read_word = '0;
      if (a == ADDR_W'(EXT_FUSE_CFG_OFS)) begin
         read_word[FUSE_CF_POS] = fuse;
      end else if (a == ADDR_W'(EXEC_STATUS_OFS)) begin
         read_word[ST_RES_LSB +: DATA_W] = res;
         read_word[ST_C_POS]             = c;
         read_word[ST_DC_POS]            = dc;
         read_word[ST_Z_POS]             = z;
         read_word[ST_SKIP_POS]          = skp;
      end
   endfunction : read_word

   // ==========================================================
   // state
   bssx_state_t               state;
   logic                      carry_chain_fuse_bit;
   logic                      accept;
   logic                      is_skip_clr;
   logic                      is_sub;
   logic [BITSEL_W-1:0]       bit_sel;
   logic                      tested_bit;
   logic                      borrow_in;
   logic [DATA_W:0]           diff;
   logic [DATA_W:0]           nib_diff;
   logic [DATA_W-1:0]         last_result;
   logic                      skip_take;
   logic                      sub_take;
   logic                      apb_wr;
   logic                      apb_rd_setup;

   // ==========================================================
   // decode
   assign o_ready     = (state == BSSX_RUN);
   assign accept      = i_issue && o_ready;
   assign is_skip_clr = (i_opcode[OPCODE_W-1:SKIP_OP_LSB] == SKIP_CLR_OP);
   assign is_sub      = (i_opcode[OPCODE_W-1:SUB_OP_LSB] == SUB_OP);
   assign bit_sel     = i_opcode[BITSEL_LSB +: BITSEL_W];
   // file address is combinational so the register file can answer
   // within the issue cycle
   assign o_fr_addr   = i_opcode[FR_ADDR_W-1:0];
   assign tested_bit  = i_file_register_operand[bit_sel];
   // one decode of each taken instruction feeds the skip, write-back and flag registers below
   assign skip_take   = accept && is_skip_clr && !tested_bit;
   assign sub_take    = accept && is_sub;

   // programmed-low fuse chains the borrow, default one ignores carry
   assign borrow_in = ~carry_chain_fuse_bit & ~i_carry;
   assign diff      = sub_borrow(i_file_register_operand, i_w, borrow_in);
   // nibble borrow includes the borrow-in, so chained digit flags stay
   // consistent with the byte carry
   assign nib_diff  = sub_borrow({{NIBBLE_W{1'b0}},
                                  i_file_register_operand[NIBBLE_W-1:0]},
                                 {{NIBBLE_W{1'b0}}, i_w[NIBBLE_W-1:0]},
                                 borrow_in);

   // ==========================================================
   // skip sequencer
   // the fetch side must drop the instruction that follows a skip pulse;
   // o_ready low keeps a second issue out of the skipped slot
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state <= BSSX_RUN;
      end else begin
         unique case (state)
            BSSX_RUN: begin
               if (skip_take) begin
                  state <= BSSX_SKIP;
               end
            end
            BSSX_SKIP: begin
               state <= BSSX_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_skip <= 1'b0;
      end else begin
         o_skip <= skip_take;
      end
   end

   // ==========================================================
   // subtract write-back, single cycle
   // waddr and wdata hold between subtracts so a slow register file
   // may latch them late; only the strobe is a pulse
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_fr_we    <= 1'b0;
         o_fr_waddr <= '0;
         o_fr_wdata <= '0;
      end else begin
         o_fr_we <= sub_take;
         if (sub_take) begin
            o_fr_waddr <= i_opcode[FR_ADDR_W-1:0];
            o_fr_wdata <= diff[DATA_W-1:0];
         end
      end
   end

   // flags move only on subtract; the skip instruction never touches them
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_flags_we           <= 1'b0;
         o_carry              <= 1'b0;
         o_nibble_borrow_flag <= 1'b0;
         o_zero               <= 1'b0;
         last_result          <= '0;
      end else begin
         o_flags_we <= sub_take;
         if (sub_take) begin
            o_carry              <= ~diff[DATA_W];
            o_nibble_borrow_flag <= ~nib_diff[NIBBLE_W];
            o_zero               <= (diff[DATA_W-1:0] == '0);
            last_result          <= diff[DATA_W-1:0];
         end
      end
   end

   // ==========================================================
   // apb slave: zero wait states, read data latched in setup phase
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !reg_hit(paddr);
   // the status word reads the flags as held, not as pending
   assign apb_wr       = psel && penable && pwrite;
   assign apb_rd_setup = psel && !penable && !pwrite;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         carry_chain_fuse_bit <= FUSE_CF_RESET;
      end else if (apb_wr && paddr == ADDR_W'(EXT_FUSE_CFG_OFS)) begin
         carry_chain_fuse_bit <= pwdata[FUSE_CF_POS];
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         prdata <= '0;
      end else if (apb_rd_setup) begin
         prdata <= read_word(paddr, carry_chain_fuse_bit, last_result,
                             o_carry, o_nibble_borrow_flag, o_zero,
                             state == BSSX_SKIP);
      end
   end
endmodule : bssx_exec

// File: hw/bssx_pkg.sv
// constants for the bit-skip and subtract execution block
package bssx_pkg;
   // ==========================================================
   // instruction encodings
   localparam logic [3:0]  SKIP_CLR_OP  = 4'h6;          // 0110 bbbf ffff
   localparam int          SKIP_OP_LSB  = 8;
   localparam logic [6:0]  SUB_OP       = 7'h05;         // 0000 101f ffff
   localparam int          SUB_OP_LSB   = 5;
   localparam int          BITSEL_LSB   = 5;
   localparam int          BITSEL_W     = 3;
   localparam int          FR_ADDR_W    = 5;
   localparam int          OPCODE_W     = 12;
   localparam int          DATA_W       = 8;
   localparam int          NIBBLE_W     = 4;

   // ==========================================================
   // register map (byte addresses on the apb)
   localparam logic [11:0] EXT_FUSE_CFG_OFS = 12'h000;
   localparam logic [11:0] EXEC_STATUS_OFS  = 12'h004;
   localparam int          FUSE_CF_POS      = 0;
   localparam logic        FUSE_CF_RESET    = 1'b1;
   // status layout: result[7:0], c[8], dc[9], z[10], skip pending[11]
   localparam int          ST_RES_LSB       = 0;
   localparam int          ST_C_POS         = 8;
   localparam int          ST_DC_POS        = 9;
   localparam int          ST_Z_POS         = 10;
   localparam int          ST_SKIP_POS      = 11;

   // ==========================================================
   // sequencer states
   typedef enum logic {
      BSSX_RUN  = 1'b0,
      BSSX_SKIP = 1'b1
   } bssx_state_t;
endpackage : bssx_pkg

// File: verif/bssx_exec_properties.sv
// concurrent checks on the ports of the skip and subtract execution block
`timescale 1ns/1ps
module bssx_exec_properties import bssx_pkg::*; (
   input wire logic        i_clk_sys, i_rst, i_issue, i_carry, o_ready,
   input wire logic        o_skip, o_fr_we, o_flags_we, o_carry, o_zero,
   input wire logic [7:0]  i_file_register_operand, i_w, o_fr_wdata,
   input wire logic [11:0] i_opcode
);
   logic       sub, skp, bz;
   logic [8:0] d;
   assign sub = i_issue && o_ready && i_opcode[11:5] == SUB_OP;
   assign skp = i_issue && o_ready && i_opcode[11:8] == SKIP_CLR_OP;
   assign bz = !i_file_register_operand[i_opcode[7:5]];
   // only checked with carry set, where borrow-in is zero either way
   assign d = {1'b0, i_file_register_operand} - i_w;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   sequence s_slot; !o_ready ##1 o_ready; endsequence
   a_skip_flag: assert property (skp |=> o_skip == $past(bz))
      else $error("skip flag wrong");
   a_skip_slot: assert property (o_skip |-> s_slot)
      else $error("skip slot length wrong");
   a_slot_refused: assert property (i_issue && !o_ready
      |=> !o_fr_we && !o_skip) else $error("instruction run in slot");
   a_sub_pulse: assert property (sub |=> o_fr_we && o_flags_we)
      else $error("subtract not done in one cycle");
   a_sub_result: assert property (sub && i_carry
      |=> {!o_carry, o_fr_wdata} == $past(d)) else $error("result wrong");
   a_zero_flag: assert property (o_flags_we |-> o_zero == !o_fr_wdata)
      else $error("zero flag wrong");
   a_flags_hold: assert property (!o_flags_we
      |-> $stable({o_carry, o_zero})) else $error("flags moved");
   a_skip_quiet: assert property (o_skip |-> !o_flags_we)
      else $error("skip touched flags");
endmodule : bssx_exec_properties
bind bssx_exec bssx_exec_properties u_props (.*);

// File: verif/bit_skip_and_subtract_exec_bench.sv
// self-checking bench for the skip and subtract execution block
`timescale 1ns/1ps
module bit_skip_and_subtract_exec_bench;
   import bssx_pkg::*;
   logic i_clk_sys = 0, i_rst = 1, i_issue = 0, i_carry = 0, psel = 0;
   logic penable = 0, pwrite = 0, o_ready, o_fr_we, o_flags_we, o_carry;
   logic o_nibble_borrow_flag, o_zero, o_skip, pready, pslverr, er, nb;
   logic [11:0] i_opcode = 0, paddr = 0;
   logic [7:0]  i_file_register_operand = 0, i_w = 0, o_fr_wdata;
   logic [4:0]  o_fr_addr, o_fr_waddr;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [8:0]  d;
   int          err_count = 0, checked = 0;
   always #2.5 i_clk_sys = ~i_clk_sys;
   bssx_exec dut (.*);
   task automatic chk(string nm, logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic close_out();
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   // apb master: request held until pready is seen high at an edge
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd);
      @(posedge i_clk_sys);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, wd};
      @(posedge i_clk_sys);
      penable <= 1'b1;
      do @(posedge i_clk_sys); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic t_sub(logic [7:0] f, ww, logic cy, fz);
      d = {1'b0, f} - ww - !(fz || cy);
      nb = f[3:0] >= {1'b0, ww[3:0]} + !(fz || cy);
      @(posedge i_clk_sys);
      {i_issue, i_opcode, i_file_register_operand, i_w, i_carry} <=
         {1'b1, SUB_OP, 5'h0d, f, ww, cy};
      @(posedge i_clk_sys);
      i_issue <= 1'b0;
      @(negedge i_clk_sys);
      chk("sub", {7'h6d, !d[8], nb, !d[7:0], d[7:0]},
         {o_fr_we, o_flags_we, o_fr_waddr, o_carry, o_nibble_borrow_flag,
          o_zero, o_fr_wdata});
      chk("fr addr", 32'hd, o_fr_addr);
   endtask : t_sub
   // a subtract waits behind the skip so that a skipped slot refuses it
   task automatic t_skip(logic [2:0] b, logic [7:0] f);
      @(posedge i_clk_sys);
      {i_issue, i_opcode, i_file_register_operand} <=
         {1'b1, SKIP_CLR_OP, b, 5'h1f, f};
      @(posedge i_clk_sys);
      {i_opcode, i_file_register_operand, i_w} <= {SUB_OP, 5'h03, 16'h0901};
      @(negedge i_clk_sys);
      chk("skip", {!f[b], f[b]}, {o_skip, o_ready});
      @(posedge i_clk_sys);
      i_issue <= 1'b0;
      @(negedge i_clk_sys);
      chk("slot", {f[b], 1'b1}, {o_fr_we, o_ready});
   endtask : t_skip
   initial begin
      repeat (8) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      apb(1'b0, EXT_FUSE_CFG_OFS, 32'h0);
      chk("fuse", 32'h1, rd);
      t_sub(8'h35, 8'h06, 1'b0, 1'b1);
      t_sub(8'h05, 8'h16, 1'b1, 1'b1);
      t_skip(3'h5, 8'hdf);
      t_skip(3'h7, 8'h80);
      apb(1'b1, EXT_FUSE_CFG_OFS, 32'h0);
      t_sub(8'h35, 8'h06, 1'b0, 1'b0);
      t_sub(8'h06, 8'h05, 1'b0, 1'b0);
      apb(1'b0, EXEC_STATUS_OFS, 32'h0);
      chk("status", 32'h700, rd);
      apb(1'b0, 12'h008, 32'h0);
      chk("unmapped", 32'h1, er);
      close_out();
   end
   initial begin
      #20000 err_count++;
      close_out();
   end
endmodule : bit_skip_and_subtract_exec_bench
